//--- logic/dlp_path_mux.sv
`timescale 1ns/1ns
`default_nettype none
module dlp_path_mux (
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    // Select bits
    input  wire logic       table_index_select_i,
    input  wire logic       dac_bypass_select_i,
    // Row and value sources
    input  wire logic [7:0] table_base_i,
    input  wire logic [5:0] table_row_index_i,
    input  wire logic [7:0] converter_result_i,
    input  wire logic [7:0] dac_direct_byte_i,
    input  wire logic [7:0] table_row_data_i,
    // Outputs
    output logic      [7:0] row_addr_o,
    output logic      [7:0] dac_code_o
);
    // ************************************************************
    // Row choice and DAC input choice
    // ************************************************************
    wire logic [5:0] row_pick;       // Chosen six bit row
    wire logic [7:0] next_dac_code;  // Chosen DAC byte
    // Row from converter top bits or from the direct index
    assign row_pick = table_index_select_i ? table_row_index_i
                                           : converter_result_i[7:2];
    // Table row byte unless bypassed by the direct byte
    assign next_dac_code = dac_bypass_select_i ? dac_direct_byte_i : table_row_data_i;
    // Register both outputs
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            row_addr_o <= dlp_pkg::BYTE_RESET;
            dac_code_o <= dlp_pkg::BYTE_RESET;
        end else begin
            row_addr_o <= dlp_pkg::dlp_row_addr(table_base_i, row_pick);
            dac_code_o <= next_dac_code;
        end
    end
endmodule : dlp_path_mux
`default_nettype wire

//--- logic/dlp_pkg.sv
package dlp_pkg;

    // ************************************************************
    // Register byte addresses
    // ************************************************************
    localparam logic [7:0] ROW_ONE_INDEX_ADDR   = 8'h81;   // First table row index
    localparam logic [7:0] ROW_TWO_INDEX_ADDR   = 8'h82;   // Second table row index
    localparam logic [7:0] DAC_ONE_DIRECT_ADDR  = 8'h83;   // First DAC direct value
    localparam logic [7:0] DAC_TWO_DIRECT_ADDR  = 8'h84;   // Second DAC direct value
    localparam logic [7:0] PATH_SELECT_ADDR     = 8'h85;   // Select and range bits
    localparam logic [7:0] WRITE_LATCH_ADDR     = 8'h86;   // Write enable latch
    localparam logic [7:0] CONVERTER_STAT_ADDR  = 8'h87;   // Converter result
    localparam logic [7:0] RESERVED_LO_ADDR     = 8'h88;   // Reserved window start
    localparam logic [7:0] RESERVED_HI_ADDR     = 8'h8F;   // Reserved window end

    // ************************************************************
    // Table base addresses
    // ************************************************************
    localparam logic [7:0] TABLE_ONE_BASE       = 8'h90;   // First table base
    localparam logic [7:0] TABLE_TWO_BASE       = 8'hD0;   // Second table base

    // ************************************************************
    // Field positions in the select and latch registers
    // ************************************************************
    localparam int SEL_DAC_TWO_BIT   = 7;                  // Second DAC bypass
    localparam int SEL_TABLE_TWO_BIT = 6;                  // Second table index select
    localparam int SEL_DAC_ONE_BIT   = 5;                  // First DAC bypass
    localparam int SEL_TABLE_ONE_BIT = 4;                  // First table index select
    localparam int RANGE_TWO_LSB     = 2;                  // Second range code low bit
    localparam int RANGE_ONE_LSB     = 0;                  // First range code low bit
    localparam int LATCH_BIT         = 7;                  // Write permit position

    // ************************************************************
    // Reset values and latch command bytes
    // ************************************************************
    localparam logic [7:0] SELECT_RESET     = 8'h00;       // All defaults
    localparam logic [7:0] BYTE_RESET       = 8'h00;       // Plain byte reset
    localparam logic [7:0] LATCH_SET_BYTE   = 8'h80;       // Sets the latch
    localparam logic [7:0] LATCH_CLEAR_BYTE = 8'h00;       // Clears the latch

    // ************************************************************
    // Full scale range decode
    // ************************************************************
    typedef enum logic [1:0] {
        DLP_RANGE_EXTERNAL,                                // Set by resistor
        DLP_RANGE_LOW,                                     // Low internal
        DLP_RANGE_MIDDLE,                                  // Middle internal
        DLP_RANGE_HIGH                                     // High internal
    } dlp_range_type;

    // Row byte address from base and six bit index
    function automatic logic [7:0] dlp_row_addr(input logic [7:0] base,
                                                input logic [5:0] index);
        dlp_row_addr = base + {2'h0, index};
    endfunction : dlp_row_addr

endpackage : dlp_pkg

//--- logic/dlp_range_decode.sv
`timescale 1ns/1ns
`default_nettype none
module dlp_range_decode (
    // Code in
    input  wire logic [1:0]            code_i,
    // Decoded range
    output var  dlp_pkg::dlp_range_type range_o,
    output logic                       external_o
);
    // ************************************************************
    // Decode
    // ************************************************************
    // Each code maps to one range choice
    always_comb begin
        unique case (code_i)
            2'h0: range_o = dlp_pkg::DLP_RANGE_EXTERNAL;
            2'h1: range_o = dlp_pkg::DLP_RANGE_LOW;
            2'h2: range_o = dlp_pkg::DLP_RANGE_MIDDLE;
            2'h3: range_o = dlp_pkg::DLP_RANGE_HIGH;
        endcase
    end
    // Only the zero code uses the external resistor
    assign external_o = (code_i == 2'h0);
endmodule : dlp_range_decode
`default_nettype wire

//--- logic/dlp_regs.sv
// What this block does
// - Stores second DAC direct byte, passes retention flag through
// - Second bypass picks direct byte, else row
// - Select register holds bypass, index, ranges
// - First range code decodes four ranges
// - Second range code decodes identically
// - Direction bits set sign independently
// - First row from converter or index
// - Second row from converter or index
// - First bypass picks direct byte, else row
// - Latch register holds write permit bit
// - Addresses 88h to 8Fh reserved, unmapped
// - Row address equals base plus index
// - Writes without latch refused except to the latch register, no acknowledge
// - Set and clear bytes drive latch
// - Status returns converter result, top bits index
`timescale 1ns/1ns
`default_nettype none
module dlp_regs (
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    // Byte access from the serial bus engine
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_write_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_read_i,
    output logic      [7:0] reg_rdata_o,
    output logic            reg_ack_o,
    output logic            reg_nack_o,
    // Retention and direction from the first control register
    input  wire logic       control_bytes_retention_i,
    input  wire logic       first_output_direction_i,
    input  wire logic       second_output_direction_i,
    // Row index bytes from the first and second row registers
    input  wire logic [5:0] first_table_row_index_i,
    input  wire logic [5:0] second_table_row_index_i,
    // Converter and table data
    input  wire logic [7:0] converter_result_bits_i,
    input  wire logic [7:0] first_table_data_i,
    input  wire logic [7:0] second_table_data_i,
    // Path outputs
    output logic      [7:0] first_table_addr_o,
    output logic      [7:0] second_table_addr_o,
    output logic      [7:0] first_dac_code_o,
    output logic      [7:0] second_dac_code_o,
    output var  dlp_pkg::dlp_range_type first_range_o,
    output var  dlp_pkg::dlp_range_type second_range_o,
    output logic            first_external_o,
    output logic            second_external_o,
    output logic            first_output_sink_o,
    output logic            second_output_sink_o,
    output logic            direct_bytes_retained_o,
    output logic            write_permit_latch_o
);
    // ************************************************************
    // Storage
    // ************************************************************
    logic [7:0] dac_one_direct_value;    // First DAC direct byte
    logic [7:0] dac_two_direct_value;    // Second DAC direct byte
    logic [7:0] path_select_and_range;   // Select and range bits
    logic       write_permit_latch;      // Write permit
    logic [7:0] converter_output_status; // Sampled converter result

    // ************************************************************
    // Decode
    // ************************************************************
    wire logic hit_one    = (reg_addr_i == dlp_pkg::DAC_ONE_DIRECT_ADDR);
    wire logic hit_two    = (reg_addr_i == dlp_pkg::DAC_TWO_DIRECT_ADDR);
    wire logic hit_select = (reg_addr_i == dlp_pkg::PATH_SELECT_ADDR);
    wire logic hit_latch  = (reg_addr_i == dlp_pkg::WRITE_LATCH_ADDR);
    wire logic hit_status = (reg_addr_i == dlp_pkg::CONVERTER_STAT_ADDR);
    // Reserved window holds nothing
    wire logic hit_rsvd   = (reg_addr_i >= dlp_pkg::RESERVED_LO_ADDR) &&
                            (reg_addr_i <= dlp_pkg::RESERVED_HI_ADDR);
    // Latch register itself is writable while the latch is clear
    wire logic wr_allowed = write_permit_latch || hit_latch;
    wire logic wr_take    = reg_write_i && wr_allowed && !hit_rsvd && !hit_status;
    wire logic latch_cmd  = (reg_wdata_i == dlp_pkg::LATCH_SET_BYTE) ||
                            (reg_wdata_i == dlp_pkg::LATCH_CLEAR_BYTE);
    wire logic [7:0] next_rdata;

    // ************************************************************
    // Register writes
    // ************************************************************
    // Store direct bytes and select bits on an allowed write
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            dac_one_direct_value  <= dlp_pkg::BYTE_RESET;
            dac_two_direct_value  <= dlp_pkg::BYTE_RESET;
            path_select_and_range <= dlp_pkg::SELECT_RESET;
        end else if (wr_take) begin
            if (hit_one) begin
                dac_one_direct_value <= reg_wdata_i;
            end
            if (hit_two) begin
                dac_two_direct_value <= reg_wdata_i;
            end
            if (hit_select) begin
                path_select_and_range <= reg_wdata_i;
            end
        end
    end
    // Latch powers up clear and follows the two command bytes
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            write_permit_latch <= 1'b0;
        end else if (wr_take && hit_latch && latch_cmd) begin
            write_permit_latch <= reg_wdata_i[dlp_pkg::LATCH_BIT];
        end
    end
    // Converter result sampled every cycle
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            converter_output_status <= dlp_pkg::BYTE_RESET;
        end else begin
            converter_output_status <= converter_result_bits_i;
        end
    end

    // ************************************************************
    // Read back and acknowledge
    // ************************************************************
    assign next_rdata = hit_one    ? dac_one_direct_value :
                        hit_two    ? dac_two_direct_value :
                        hit_select ? path_select_and_range :
                        hit_latch  ? {write_permit_latch, 7'h00} :
                        hit_status ? converter_output_status :
                                     dlp_pkg::BYTE_RESET;
    // Answer one cycle after each access
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= dlp_pkg::BYTE_RESET;
            reg_ack_o   <= 1'b0;
            reg_nack_o  <= 1'b0;
        end else begin
            reg_rdata_o <= reg_read_i ? next_rdata : reg_rdata_o;
            reg_ack_o   <= reg_read_i || wr_take;
            reg_nack_o  <= reg_write_i && !wr_take;
        end
    end

    // ************************************************************
    // Path selection
    // ************************************************************
    dlp_path_mux u_path_one (
        .sys_clk_i            (sys_clk_i),
        .rst_i                (rst_i),
        .table_index_select_i (path_select_and_range[dlp_pkg::SEL_TABLE_ONE_BIT]),
        .dac_bypass_select_i  (path_select_and_range[dlp_pkg::SEL_DAC_ONE_BIT]),
        .table_base_i         (dlp_pkg::TABLE_ONE_BASE),
        .table_row_index_i    (first_table_row_index_i),
        .converter_result_i   (converter_output_status),
        .dac_direct_byte_i    (dac_one_direct_value),
        .table_row_data_i     (first_table_data_i),
        .row_addr_o           (first_table_addr_o),
        .dac_code_o           (first_dac_code_o)
    );
    dlp_path_mux u_path_two (
        .sys_clk_i            (sys_clk_i),
        .rst_i                (rst_i),
        .table_index_select_i (path_select_and_range[dlp_pkg::SEL_TABLE_TWO_BIT]),
        .dac_bypass_select_i  (path_select_and_range[dlp_pkg::SEL_DAC_TWO_BIT]),
        .table_base_i         (dlp_pkg::TABLE_TWO_BASE),
        .table_row_index_i    (second_table_row_index_i),
        .converter_result_i   (converter_output_status),
        .dac_direct_byte_i    (dac_two_direct_value),
        .table_row_data_i     (second_table_data_i),
        .row_addr_o           (second_table_addr_o),
        .dac_code_o           (second_dac_code_o)
    );

    // ************************************************************
    // Range decode and direction
    // ************************************************************
    dlp_range_decode u_range_one (
        .code_i     (path_select_and_range[dlp_pkg::RANGE_ONE_LSB +: 2]),
        .range_o    (first_range_o),
        .external_o (first_external_o)
    );
    dlp_range_decode u_range_two (
        .code_i     (path_select_and_range[dlp_pkg::RANGE_TWO_LSB +: 2]),
        .range_o    (second_range_o),
        .external_o (second_external_o)
    );
    // Sign comes only from direction bits
    assign first_output_sink_o     = first_output_direction_i;
    assign second_output_sink_o    = second_output_direction_i;
    assign direct_bytes_retained_o = control_bytes_retention_i;
    assign write_permit_latch_o    = write_permit_latch;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    // Writes refused while the latch is clear
    latch_guard_a: assert property (
        reg_write_i && !write_permit_latch && !hit_latch |=> reg_nack_o && !reg_ack_o)
        else $error("write without latch was not refused");

    // Refused write leaves select bits alone
    refused_keep_a: assert property (
        reg_write_i && !write_permit_latch && !hit_latch |=> $stable(path_select_and_range))
        else $error("refused write changed select bits");

    // Set byte turns the latch on
    latch_set_a: assert property (
        reg_write_i && hit_latch && reg_wdata_i == dlp_pkg::LATCH_SET_BYTE
        |=> write_permit_latch)
        else $error("latch did not set");

    // Clear byte turns the latch off
    latch_clear_a: assert property (
        reg_write_i && hit_latch && reg_wdata_i == dlp_pkg::LATCH_CLEAR_BYTE
        |=> !write_permit_latch)
        else $error("latch did not clear");

    // Other bytes leave the latch alone
    latch_odd_a: assert property (
        reg_write_i && hit_latch && !latch_cmd |=> $stable(write_permit_latch))
        else $error("latch moved on odd byte");

    // Reserved latch bits read as zero
    rsvd_zero_a: assert property (
        reg_read_i && hit_latch |=> reg_rdata_o[6:0] == 7'h00)
        else $error("latch reserved bits not zero");

    // Reserved window refuses writes
    rsvd_block_a: assert property (
        reg_write_i && hit_rsvd |=> reg_nack_o)
        else $error("reserved write accepted");

    // Permitted write lands in second direct byte
    dac_two_store_a: assert property (
        reg_write_i && write_permit_latch && hit_two
        |=> dac_two_direct_value == $past(reg_wdata_i))
        else $error("second direct byte not stored");

    // Second bypass passes the direct byte
    dac_two_a: assert property (
        path_select_and_range[dlp_pkg::SEL_DAC_TWO_BIT] && $stable(dac_two_direct_value)
        |=> second_dac_code_o == $past(dac_two_direct_value))
        else $error("second bypass wrong");

    // Second DAC takes the row by default
    dac_two_row_a: assert property (
        !path_select_and_range[dlp_pkg::SEL_DAC_TWO_BIT]
        |=> second_dac_code_o == $past(second_table_data_i))
        else $error("second table byte not used");

    // First DAC takes the row by default
    dac_one_a: assert property (
        !path_select_and_range[dlp_pkg::SEL_DAC_ONE_BIT]
        |=> first_dac_code_o == $past(first_table_data_i))
        else $error("first table byte not used");

    // First bypass passes the direct byte
    dac_one_direct_a: assert property (
        path_select_and_range[dlp_pkg::SEL_DAC_ONE_BIT]
        |=> first_dac_code_o == $past(dac_one_direct_value))
        else $error("first bypass wrong");

    // First row from converter by default
    row_one_a: assert property (
        !path_select_and_range[dlp_pkg::SEL_TABLE_ONE_BIT]
        |=> first_table_addr_o ==
            dlp_pkg::TABLE_ONE_BASE + {2'h0, $past(converter_output_status[7:2])})
        else $error("first row not from converter");

    // Direct first row is base plus index
    row_one_index_a: assert property (
        path_select_and_range[dlp_pkg::SEL_TABLE_ONE_BIT]
        |=> first_table_addr_o ==
            dlp_pkg::TABLE_ONE_BASE + {2'h0, $past(first_table_row_index_i)})
        else $error("first row not from index");

    // Direct second row is base plus index
    row_two_a: assert property (
        path_select_and_range[dlp_pkg::SEL_TABLE_TWO_BIT]
        |=> second_table_addr_o ==
            dlp_pkg::TABLE_TWO_BASE + {2'h0, $past(second_table_row_index_i)})
        else $error("second row not from index");

    // Second row from converter by default
    row_two_conv_a: assert property (
        !path_select_and_range[dlp_pkg::SEL_TABLE_TWO_BIT]
        |=> second_table_addr_o ==
            dlp_pkg::TABLE_TWO_BASE + {2'h0, $past(converter_output_status[7:2])})
        else $error("second row not from converter");

    // Status read returns sampled converter byte
    status_a: assert property (
        reg_read_i && hit_status |=> reg_rdata_o == $past(converter_output_status))
        else $error("status read wrong");

    // Status register refuses writes
    status_ro_a: assert property (
        reg_write_i && hit_status |=> reg_nack_o)
        else $error("status write accepted");

    // Top first code picks the high range
    range_one_a: assert property (
        path_select_and_range[dlp_pkg::RANGE_ONE_LSB +: 2] == 2'h3
        |-> first_range_o == dlp_pkg::DLP_RANGE_HIGH && !first_external_o)
        else $error("first range decode wrong");

    // Code one picks the low second range
    range_two_a: assert property (
        path_select_and_range[dlp_pkg::RANGE_TWO_LSB +: 2] == 2'h1
        |-> second_range_o == dlp_pkg::DLP_RANGE_LOW && !second_external_o)
        else $error("second range decode wrong");

    latch_set_c: cover property (reg_write_i && hit_latch && reg_wdata_i == dlp_pkg::LATCH_SET_BYTE);
    refused_c:   cover property (reg_nack_o);
    bypass_c:    cover property (path_select_and_range[dlp_pkg::SEL_DAC_TWO_BIT]);
    index_c:     cover property (path_select_and_range[dlp_pkg::SEL_TABLE_ONE_BIT]);
    index_two_c: cover property (path_select_and_range[dlp_pkg::SEL_TABLE_TWO_BIT]);
endmodule : dlp_regs
`default_nettype wire

//--- verif/dlp_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module dlp_regs_tb;
    // ************************************************************
    // Stimulus and observed signals
    // ************************************************************
    logic                   sys_clk = 1'b0;  // 125 MHz clock
    logic                   rst     = 1'b1;  // Synchronous reset
    logic [7:0]             addr    = 8'h00; // Byte address
    logic                   wr_en   = 1'b0;  // Write strobe
    logic [7:0]             wdata   = 8'h00; // Write byte
    logic                   rd_en   = 1'b0;  // Read strobe
    logic                   retain  = 1'b0;  // Retention flag
    logic                   dir_one = 1'b0;  // First direction
    logic                   dir_two = 1'b0;  // Second direction
    logic [5:0]             idx_one = 6'h3F; // First direct row index
    logic [5:0]             idx_two = 6'h2E; // Second direct row index
    logic [7:0]             conv    = 8'h6B; // Converter result
    logic [7:0]             rdata, ta1, ta2, td1, td2, dac1, dac2, sel, e1, e2;
    logic                   ack, nack, ext1, ext2, sink1, sink2, kept, latch;
    dlp_pkg::dlp_range_type rng1, rng2;      // Decoded ranges
    int                     err_count    = 0; // Mismatches
    int                     total_checks = 0; // Comparisons made

    // Clock generator
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    dlp_regs dlp_regs_inst (
        .sys_clk_i(sys_clk), .rst_i(rst), .reg_addr_i(addr), .reg_write_i(wr_en),
        .reg_wdata_i(wdata), .reg_read_i(rd_en), .reg_rdata_o(rdata), .reg_ack_o(ack),
        .reg_nack_o(nack), .control_bytes_retention_i(retain),
        .first_output_direction_i(dir_one), .second_output_direction_i(dir_two),
        .first_table_row_index_i(idx_one), .second_table_row_index_i(idx_two),
        .converter_result_bits_i(conv), .first_table_data_i(td1),
        .second_table_data_i(td2), .first_table_addr_o(ta1), .second_table_addr_o(ta2),
        .first_dac_code_o(dac1), .second_dac_code_o(dac2), .first_range_o(rng1),
        .second_range_o(rng2), .first_external_o(ext1), .second_external_o(ext2),
        .first_output_sink_o(sink1), .second_output_sink_o(sink2),
        .direct_bytes_retained_o(kept), .write_permit_latch_o(latch)
    );

    dlp_table_model dlp_table_model_inst (
        .first_addr_i(ta1), .second_addr_i(ta2), .first_data_o(td1), .second_data_o(td2)
    );

    // ************************************************************
    // Access and compare tasks
    // ************************************************************
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Write one byte from a falling edge, check the answer a cycle later
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ok);
        addr  = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge sys_clk);
        wr_en = 1'b0;
        chk("write ack", {7'h0, ok}, {7'h0, ack});
        chk("write nack", {7'h0, !ok}, {7'h0, nack});
        // Strobe stays low across one edge before the next access
        @(negedge sys_clk);
    endtask : wr

    // Read one byte, data comes with the ack
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        addr  = a;
        rd_en = 1'b1;
        @(negedge sys_clk);
        rd_en = 1'b0;
        chk("read ack", 8'h01, {7'h0, ack});
        chk("read data", exp, rdata);
        // Strobe stays low across one edge before the next access
        @(negedge sys_clk);
    endtask : rd

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        repeat (10) @(negedge sys_clk);
        rst = 1'b0;
        // Reset state
        rd(8'h85, 8'h00);
        rd(8'h86, 8'h00);
        chk("range one", 8'h00, {6'h0, rng1});
        chk("external two", 8'h01, {7'h0, ext2});
        // Writes refused until the latch is set
        wr(8'h83, 8'h11, 1'b0);
        rd(8'h83, 8'h00);
        wr(8'h86, 8'h80, 1'b1);
        chk("latch", 8'h01, {7'h0, latch});
        wr(8'h86, 8'hFF, 1'b1);
        rd(8'h86, 8'h80);
        wr(8'h83, 8'hA5, 1'b1);
        wr(8'h84, 8'h3C, 1'b1);
        rd(8'h83, 8'hA5);
        rd(8'h84, 8'h3C);
        // Status is read only, reserved window is unmapped
        wr(8'h87, 8'h55, 1'b0);
        rd(8'h87, 8'h6B);
        wr(8'h8A, 8'h55, 1'b0);
        rd(8'h88, 8'h00);
        rd(8'h8F, 8'h00);
        // Two select combinations and every range code
        for (int i = 0; i < 4; i++) begin
            sel = {(i[0] ? 4'hA : 4'h5), 2'(3 - i), 2'(i)};
            wr(8'h85, sel, 1'b1);
            rd(8'h85, sel);
            repeat (4) @(negedge sys_clk);
            e1 = dlp_pkg::TABLE_ONE_BASE + {2'h0, (i[0] ? conv[7:2] : idx_one)};
            e2 = dlp_pkg::TABLE_TWO_BASE + {2'h0, (i[0] ? conv[7:2] : idx_two)};
            chk("row one addr", e1, ta1);
            chk("row two addr", e2, ta2);
            chk("dac one", (i[0] ? 8'hA5 : ~e1), dac1);
            chk("dac two", (i[0] ? 8'h3C : e2 ^ 8'h3C), dac2);
            chk("range one", 8'(i), {6'h0, rng1});
            chk("range two", 8'(3 - i), {6'h0, rng2});
            chk("external one", {7'h0, i == 0}, {7'h0, ext1});
            chk("external two", {7'h0, i == 3}, {7'h0, ext2});
        end
        // Direction and retention follow their inputs
        for (int k = 0; k < 2; k++) begin
            dir_one = k[0];
            dir_two = !k[0];
            retain  = k[0];
            @(negedge sys_clk);
            chk("sink one", {7'h0, k[0]}, {7'h0, sink1});
            chk("sink two", {7'h0, !k[0]}, {7'h0, sink2});
            chk("retained", {7'h0, k[0]}, {7'h0, kept});
        end
        // Clearing the latch blocks writes again
        wr(8'h86, 8'h00, 1'b1);
        chk("latch", 8'h00, {7'h0, latch});
        wr(8'h84, 8'h77, 1'b0);
        rd(8'h84, 8'h3C);
        summarize();
    end

    // Watchdog cuts a hang short
    initial begin
        repeat (2000) @(posedge sys_clk);
        err_count++;
        $display("ERROR watchdog expected done seen timeout");
        summarize();
    end
endmodule : dlp_regs_tb
`default_nettype wire

//--- verif/dlp_table_model.sv
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// Table rows seen by the two paths
// ************************************************************
module dlp_table_model (
    // Row byte addresses from the block
    input  wire logic [7:0] first_addr_i,
    input  wire logic [7:0] second_addr_i,
    // Row bytes back to the block
    output logic      [7:0] first_data_o,
    output logic      [7:0] second_data_o
);
    // Each row holds a byte derived from its address, so a wrong row shows
    assign first_data_o  = ~first_addr_i;
    assign second_data_o = second_addr_i ^ 8'h3C;
endmodule : dlp_table_model
`default_nettype wire
